// File: wcco_core.sv
// Top: executes watchdog clear, complement and compare-skip instructions
`default_nettype none
// How it works
// RULE1: Watchdog clear zeroes counter and postscaler
// RULE2: Watchdog clear sets timeout, powerdown flags only
// RULE3: Watchdog clear fixed opcode, one cycle
// RULE4: Complement file, result to W or file
// RULE5: Complement decoded by pattern, sets N, Z
// RULE6: Bank bit selects access bank or BANK_SELECT_REGISTER bank
// RULE7: Extended set, access, f<=95: indexed offset
// RULE8: Compare equal skips when file equals W
// RULE9: Compare greater skips when file exceeds W
// RULE10: Skip replaces fetched instructions with no-ops
module wcco_core
    import wcco_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Instruction stream
    input wire logic insnValid,
    input wire logic [15:0] insn,
    input wire logic insnTwoWord,
    input wire logic extEnable,
    // Register file read port (value for current fileAddr)
    input wire logic [7:0] fileRdData,
    output logic [11:0] fileAddr,
    // Register file write port
    output logic fileWe,
    output logic [11:0] fileWrAddr,
    output logic [7:0] fileWrData,
    // Bank select write and watchdog
    input wire logic bsrWe,
    input wire logic [3:0] bsrWrData,
    input wire logic [7:0] fsrBase,
    output logic wdtClear,
    // Architectural state
    output logic [7:0] wreg,
    output logic [7:0] status,
    output logic [3:0] bankSel,
    output logic skipping,
    output logic insnDone
);
    wcco_dec_if dif();
    logic [7:0] wreg_reg, wreg_next;
    logic [7:0] status_reg, status_next;
    logic [3:0] bsr_reg;
    logic [1:0] skipCnt_reg, skipCnt_next;
    logic execOk;
    logic [7:0] compl;
    logic takeSkip;

    assign dif.insn = insn;
    assign dif.extEnable = extEnable;
    assign dif.bankSel = bsr_reg;
    assign dif.fsrBase = fsrBase;

    wcco_decode u_dec (
        .d(dif)
    );

    // Read address is combinational so the file answers in the same cycle
    assign fileAddr = dif.fileAddr;
    // Squashed words are not executed
    assign execOk = insnValid && (skipCnt_reg == 2'd0);
    assign compl = ~fileRdData; // RULE4
    always_comb begin
        takeSkip = 1'b0;
        if (execOk && dif.opClass == WCCO_CMP) begin
            if (dif.cmpGreater) begin
                takeSkip = (fileRdData > wreg_reg); // RULE9
            end else begin
                takeSkip = (8'(fileRdData - wreg_reg) == 8'h00); // RULE8
            end
        end
    end

    // Working register and status next values
    always_comb begin
        wreg_next = wreg_reg;
        status_next = status_reg;
        if (execOk) begin
            case (dif.opClass)
                WCCO_WDTCLR: begin
                    status_next[WCCO_STAT_TO] = 1'b1; // RULE2
                    status_next[WCCO_STAT_PD] = 1'b1; // RULE2
                end
                WCCO_COMPLEMENT_FILE_OP: begin
                    if (!dif.destFile) begin
                        wreg_next = compl; // RULE4
                    end
                    status_next[WCCO_STAT_N] = compl[7]; // RULE5
                    status_next[WCCO_STAT_Z] = (compl == 8'h00); // RULE5
                end
                // Compares leave every flag alone
                WCCO_CMP: status_next = status_reg; // RULE9
                default: status_next = status_reg;
            endcase
        end
    end

    // Skip counter: one squash, two if the next word pair is a two-word op
    always_comb begin
        skipCnt_next = skipCnt_reg;
        if (takeSkip) begin
            skipCnt_next = 2'd1; // RULE10
        end else if (insnValid && skipCnt_reg != 2'd0) begin
            // Second word of a squashed two-word op also becomes a no-op
            if (skipCnt_reg == 2'd1 && insnTwoWord) begin
                skipCnt_next = 2'd2; // RULE10
            end else begin
                skipCnt_next = 2'd0;
            end
        end
    end

    // Architectural registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wreg_reg <= WCCO_RESET_WREG;
            status_reg <= WCCO_RESET_STATUS;
            skipCnt_reg <= 2'd0;
        end else begin
            wreg_reg <= wreg_next;
            status_reg <= status_next;
            skipCnt_reg <= skipCnt_next;
        end
    end

    // Bank select register, software loaded
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bsr_reg <= WCCO_RESET_BSR;
        end else if (bsrWe) begin
            bsr_reg <= bsrWrData;
        end
    end

    // Registered side effects: file write and watchdog clear pulse
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fileWe <= 1'b0;
            fileWrAddr <= WCCO_RESET_ADDR;
            fileWrData <= 8'h00;
            wdtClear <= 1'b0;
            insnDone <= 1'b0;
        end else begin
            fileWe <= execOk && dif.opClass == WCCO_COMPLEMENT_FILE_OP && dif.destFile; // RULE4
            fileWrAddr <= dif.fileAddr;
            fileWrData <= compl;
            // Counter and postscaler are zeroed together by the watchdog
            wdtClear <= execOk && dif.opClass == WCCO_WDTCLR; // RULE1
            insnDone <= insnValid; // RULE3
        end
    end

    // Mirrors of architectural state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wreg <= WCCO_RESET_WREG;
            status <= WCCO_RESET_STATUS;
            bankSel <= WCCO_RESET_BSR;
            skipping <= 1'b0;
        end else begin
            wreg <= wreg_next;
            status <= status_next;
            bankSel <= bsrWe ? bsrWrData : bsr_reg;
            skipping <= (skipCnt_next != 2'd0);
        end
    end
endmodule
`default_nettype wire

// File: wcco_pkg.sv
// Package: opcodes, field positions, status bit positions and constants
`default_nettype none
package wcco_pkg;
    localparam logic [15:0] WCCO_OP_WDT_CLEAR = 16'h0004;
    localparam logic [5:0] WCCO_OP_COMPLEMENT_FILE_OP = 6'h07;
    localparam logic [6:0] WCCO_OP_COMPARE_SKIP_EQUAL_OP = 7'h31;
    localparam logic [6:0] WCCO_OP_COMPARE_SKIP_GREATER_OP = 7'h32;
    localparam int WCCO_DEST_BIT = 9;
    localparam int WCCO_BANK_BIT = 8;
    localparam logic [7:0] WCCO_ILO_LIMIT = 8'h5f;
    localparam logic [7:0] WCCO_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] WCCO_ACCESS_HIGH_BANK = 4'hf;
    localparam int WCCO_STAT_N = 4;
    localparam int WCCO_STAT_Z = 2;
    localparam int WCCO_STAT_PD = 5;
    localparam int WCCO_STAT_TO = 6;
    localparam logic [7:0] WCCO_RESET_STATUS = 8'h60;
    localparam logic [7:0] WCCO_RESET_WREG = 8'h00;
    localparam logic [3:0] WCCO_RESET_BSR = 4'h0;
    localparam logic [11:0] WCCO_RESET_ADDR = 12'h000;
    typedef enum logic [1:0] {WCCO_NONE, WCCO_WDTCLR, WCCO_COMPLEMENT_FILE_OP, WCCO_CMP} wcco_class_t;
endpackage
`default_nettype wire

// File: wcco_dec_if.sv
// Interface: decoded operation between decoder and executing core
`default_nettype none
interface wcco_dec_if;
    import wcco_pkg::*;
    logic [15:0] insn;
    logic extEnable;
    logic [3:0] bankSel;
    logic [7:0] fsrBase;
    wcco_class_t opClass;
    logic destFile;
    logic cmpGreater;
    logic [11:0] fileAddr;
    modport dec (input insn, input extEnable, input bankSel, input fsrBase,
                 output opClass, output destFile, output cmpGreater, output fileAddr);
    modport core (output insn, output extEnable, output bankSel, output fsrBase,
                  input opClass, input destFile, input cmpGreater, input fileAddr);
endinterface
`default_nettype wire

// File: wcco_decode.sv
// Decoder: opcode match and effective file address
`default_nettype none
module wcco_decode
    import wcco_pkg::*;
(
    wcco_dec_if.dec d
);
    logic bankBit;
    logic [7:0] fOff;
    logic [7:0] iloSum;
    assign bankBit = d.insn[WCCO_BANK_BIT];
    assign fOff = d.insn[7:0];
    assign iloSum = 8'(d.fsrBase + fOff);

    // Opcode classification
    always_comb begin
        d.opClass = WCCO_NONE;
        d.cmpGreater = 1'b0;
        if (d.insn == WCCO_OP_WDT_CLEAR) begin // RULE3
            d.opClass = WCCO_WDTCLR;
        end else if (d.insn[15:10] == WCCO_OP_COMPLEMENT_FILE_OP) begin // RULE5
            d.opClass = WCCO_COMPLEMENT_FILE_OP;
        end else if (d.insn[15:9] == WCCO_OP_COMPARE_SKIP_EQUAL_OP || d.insn[15:9] == WCCO_OP_COMPARE_SKIP_GREATER_OP) begin
            d.opClass = WCCO_CMP;
            d.cmpGreater = (d.insn[15:9] == WCCO_OP_COMPARE_SKIP_GREATER_OP);
        end
    end
    assign d.destFile = d.insn[WCCO_DEST_BIT];

    // Address: banked, access bank, or indexed literal offset
    always_comb begin
        if (bankBit) begin
            d.fileAddr = {d.bankSel, fOff}; // RULE6
        end else if (d.extEnable && fOff <= WCCO_ILO_LIMIT) begin
            d.fileAddr = {4'h0, iloSum}; // RULE7
        end else if (fOff < WCCO_ACCESS_SPLIT) begin
            d.fileAddr = {4'h0, fOff}; // RULE6
        end else begin
            d.fileAddr = {WCCO_ACCESS_HIGH_BANK, fOff};
        end
    end
endmodule
`default_nettype wire

// File: wcco_core_checker.sv
// Checker: concurrent assertions on the instruction core ports
`default_nettype none
module wcco_core_checker
    import wcco_pkg::*;
(
    // Watched core ports
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic insnValid,
    input wire logic [15:0] insn,
    input wire logic insnTwoWord,
    input wire logic extEnable,
    input wire logic [7:0] fileRdData,
    input wire logic [11:0] fileAddr,
    input wire logic fileWe,
    input wire logic [11:0] fileWrAddr,
    input wire logic [7:0] fileWrData,
    input wire logic [7:0] fsrBase,
    input wire logic wdtClear,
    input wire logic [7:0] wreg,
    input wire logic [7:0] status,
    input wire logic [3:0] bankSel,
    input wire logic skipping
);
    timeunit 1ns;
    timeprecision 1ns;
    logic taken;
    logic isComf;
    logic isCmp;
    // Decode helpers; a squashed word never counts as taken
    assign taken = insnValid && !skipping;
    assign isComf = insn[15:10] == WCCO_OP_COMPLEMENT_FILE_OP;
    assign isCmp = insn[15:9] == WCCO_OP_COMPARE_SKIP_EQUAL_OP || insn[15:9] == WCCO_OP_COMPARE_SKIP_GREATER_OP;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_wdt; taken && insn == WCCO_OP_WDT_CLEAR; endsequence
    sequence s_complement_file_op; taken && isComf; endsequence
    sequence s_cmp; taken && isCmp; endsequence
    chk_wdt_pulse: assert property (s_wdt |=> wdtClear && status[6:5] == 2'b11) else $error("wdt clear");
    chk_wdt_only: assert property (s_wdt |=> {status[7], status[4:0]} == $past({status[7], status[4:0]}) &&
        $stable(wreg)) else $error("wdt side effect");
    chk_complement_file_op_wreg: assert property (s_complement_file_op ##0 !insn[9] |=> wreg == ~$past(fileRdData) &&
        status[4] == wreg[7] && status[2] == (wreg == 8'h00)) else $error("complement_file_op to w");
    chk_complement_file_op_file: assert property (s_complement_file_op ##0 insn[9] |=> fileWe && fileWrData == ~$past(fileRdData) &&
        fileWrAddr == $past(fileAddr)) else $error("complement_file_op to file");
    chk_bank_pick: assert property ((isComf || isCmp) && !(!insn[8] && extEnable && insn[7:0] <= 8'h5f) |->
        fileAddr == (insn[8] ? {bankSel, insn[7:0]} : {(insn[7:0] >= 8'h60) ? 4'hf : 4'h0, insn[7:0]}))
        else $error("bank address");
    chk_ilo_addr: assert property ((isComf || isCmp) && !insn[8] && extEnable && insn[7:0] <= 8'h5f |->
        fileAddr == {4'h0, 8'(fsrBase + insn[7:0])}) else $error("indexed address");
    chk_cmp_skip: assert property (s_cmp |=> $stable(status) && skipping == ($past(insn[10]) ?
        $past(fileRdData) > $past(wreg) : $past(fileRdData) == $past(wreg))) else $error("compare skip");
    chk_squash_one: assert property (skipping && insnValid && !insnTwoWord |=> $stable(wreg) &&
        !fileWe && !wdtClear && !skipping) else $error("squash");
    chk_squash_two: assert property (skipping && insnValid && insnTwoWord |=> skipping && !wdtClear &&
        !fileWe) else $error("two word squash");
endmodule
bind wcco_core wcco_core_checker chk_u (.*);
`default_nettype wire

// File: testbench.sv
// Testbench: drives instruction words and checks core state
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import wcco_pkg::*;
    logic sys_clk = 0, arst_n = 0, insnValid = 0, insnTwoWord = 0, extEnable = 0, bsrWe = 0;
    logic [15:0] insn = 0;
    logic [7:0] fileRdData = 0, fsrBase = 0;
    logic [3:0] bsrWrData = 0;
    logic [11:0] fileAddr, fileWrAddr;
    logic fileWe, wdtClear, skipping, insnDone;
    logic [7:0] fileWrData, wreg, status;
    logic [3:0] bankSel;
    int errors = 0, n_checks = 0;
    wcco_core dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .insnValid(insnValid), .insn(insn),
        .insnTwoWord(insnTwoWord), .extEnable(extEnable), .fileRdData(fileRdData), .fileAddr(fileAddr),
        .fileWe(fileWe), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .bsrWe(bsrWe), .bsrWrData(bsrWrData),
        .fsrBase(fsrBase), .wdtClear(wdtClear), .wreg(wreg), .status(status), .bankSel(bankSel),
        .skipping(skipping), .insnDone(insnDone));
    always #5 sys_clk = ~sys_clk;
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One instruction word, driven on an edge, taken at the next; an idle cycle follows
    task run(input logic [15:0] w, input logic [7:0] d, input logic tw);
        @(posedge sys_clk);
        insn <= w;
        fileRdData <= d;
        insnTwoWord <= tw;
        insnValid <= 1'b1;
        @(posedge sys_clk);
        insnValid <= 1'b0;
        #1;
    endtask
    // Bank select load, strobe changed on edges only
    task setBank(input logic [3:0] b);
        @(posedge sys_clk);
        bsrWe <= 1'b1;
        bsrWrData <= b;
        @(posedge sys_clk);
        bsrWe <= 1'b0;
        #1;
    endtask
    // Address is combinational, so it is read mid-cycle with no word taken
    task addr(input logic [15:0] w, input logic [11:0] exp);
        @(posedge sys_clk);
        insn <= w;
        @(negedge sys_clk);
        chk("fileAddr", exp, fileAddr);
    endtask
    // Values status, wreg, bankSel, fileWe, wdtClear, skipping and insnDone must show straight after a reset
    task chkReset;
        chk("status", 16'h0060, status);
        chk("wreg", 16'h0000, wreg);
        chk("fileWe", 16'h0000, fileWe);
        chk("wdtClear", 16'h0000, wdtClear);
        chk("skipping", 16'h0000, skipping);
        chk("bankSel", 16'h0000, bankSel);
        chk("insnDone", 16'h0000, insnDone);
    endtask
    task conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #100000;
        errors++;
        conclude;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chkReset;
        setBank(4'h3);
        chk("bankSel", 16'h0003, bankSel);
        run(16'h1c05, 8'h13, 0);
        chk("wreg", 16'h00ec, wreg);
        chk("status", 16'h0070, status);
        chk("insnDone", 16'h0001, insnDone);
        run(16'h1fa0, 8'hff, 0);
        chk("fileWe", 16'h0001, fileWe);
        chk("fileWrData", 16'h0000, fileWrData);
        chk("fileWrAddr", 16'h03a0, fileWrAddr);
        chk("status", 16'h0064, status);
        run(WCCO_OP_WDT_CLEAR, 8'h00, 0);
        chk("wdtClear", 16'h0001, wdtClear);
        chk("status", 16'h0064, status);
        chk("fileWe", 16'h0000, fileWe);
        // Unrecognised word: nothing may happen
        run(16'h0000, 8'h55, 0);
        chk("wdtClear", 16'h0000, wdtClear);
        chk("wreg", 16'h00ec, wreg);
        run(16'h6205, 8'hec, 0);
        chk("skipping", 16'h0001, skipping);
        run(16'h1c05, 8'h00, 0);
        chk("wreg", 16'h00ec, wreg);
        run(16'h6405, 8'hed, 0);
        chk("skipping", 16'h0001, skipping);
        chk("status", 16'h0064, status);
        run(WCCO_OP_WDT_CLEAR, 8'h00, 1);
        chk("wdtClear", 16'h0000, wdtClear);
        chk("skipping", 16'h0001, skipping);
        run(16'h1c05, 8'h00, 0);
        chk("wreg", 16'h00ec, wreg);
        chk("skipping", 16'h0000, skipping);
        run(16'h6405, 8'hec, 0);
        chk("skipping", 16'h0000, skipping);
        run(16'h6405, 8'h01, 0);
        chk("skipping", 16'h0000, skipping);
        run(16'h6305, 8'hed, 0);
        chk("skipping", 16'h0000, skipping);
        run(16'h6205, 8'hec, 0);
        chk("skipping", 16'h0001, skipping);
        // Reset in mid-run with a skip pending: the pending squash must be dropped
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chkReset;
        setBank(4'h3);
        run(16'h1c05, 8'h5a, 0);
        chk("wreg", 16'h00a5, wreg);
        chk("status", 16'h0070, status);
        addr(16'h1c10, 12'h010);
        addr(16'h1c80, 12'hf80);
        addr(16'h1d10, 12'h310);
        @(posedge sys_clk);
        extEnable <= 1'b1;
        fsrBase <= 8'h20;
        addr(16'h1c5f, 12'h07f);
        addr(16'h1c60, 12'hf60);
        addr(16'h1d10, 12'h310);
        conclude;
    end
endmodule
`default_nettype wire
